// >>> rtl/seq_ctrl_pkg.sv
// Constants, types and register map shared by the sequence start and jump logic.
package seq_ctrl_pkg;

  // Clock rate and documented times.
  localparam int CLK_HZ         = 25_000_000;
  localparam int START_DELAY_MS = 2;
  localparam int CMD_TIME_MS    = 1;
  localparam int CMD_LONG_MS    = 2;

  // Least time rounds up; execution times are exact multiples of the period.
  localparam int START_DELAY_CYC = (CLK_HZ / 1000 * START_DELAY_MS * 1000 + 999) / 1000;
  localparam int CMD_CYC         = CLK_HZ / 1000 * CMD_TIME_MS;
  localparam int CMD_LONG_CYC    = CLK_HZ / 1000 * CMD_LONG_MS;

  // Start condition settings.
  localparam logic [2:0] SET_TWO_INPUT = 3'h0;
  localparam logic [2:0] SET_TERM      = 3'h1;
  localparam logic [2:0] SET_CTRL      = 3'h4;

  // Storage sizes.
  localparam int PROG_DEPTH = 16;
  localparam int NUM_FLAGS  = 4;
  localparam int NUM_CNT    = 4;
  localparam int NUM_VAR    = 4;
  localparam int INSTR_W    = 24;
  localparam int ADDR_W     = 6;

  // Register offsets (word indices on the plain port).
  localparam logic [ADDR_W-1:0] ADDR_PROG_BASE = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS     = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_CNT_BASE  = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_VAR_BASE  = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 6'h1C;

  // Reset values.
  localparam logic [15:0] CNT16_RST = 16'h0000;
  localparam logic [3:0]  LINE_RST  = 4'h0;

  typedef enum logic [3:0] {
    OP_JMP       = 4'h0,
    OP_JMP_WIN   = 4'h1,
    OP_JMP_TGT   = 4'h2,
    OP_JMP_FLAG  = 4'h3,
    OP_JMP_FLAGX = 4'h4,
    OP_JMP_VARK  = 4'h5,
    OP_JMP_VARXK = 4'h6,
    OP_JMP_VARV  = 4'h7,
    OP_JMP_CNT   = 4'h8,
    OP_NOP       = 4'hE,
    OP_END       = 4'hF
  } op_e;

  typedef enum logic [1:0] {
    REL_LESS    = 2'h0,
    REL_EQUAL   = 2'h1,
    REL_GREATER = 2'h2
  } rel_e;

  typedef enum logic [1:0] {
    TGT_LINE = 2'h0,
    TGT_END  = 2'h1,
    TGT_CALL = 2'h2
  } tgt_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN  = 2'b01,
    SEQ_HOME = 2'b11
  } seq_state_e;

  // One program line.
  typedef struct packed {
    op_e        op;
    rel_e       rel;
    logic       bit_val;
    logic [1:0] idx_a;
    logic [1:0] idx_b;
    tgt_e       tgt;
    logic [3:0] line;
    logic [6:0] konst;
  } instr_s;

  // Synchronised terminal levels.
  typedef struct packed {
    logic cam;
    logic launch;
    logic auto_sel;
    logic start;
    logic enable;
  } pins_s;

endpackage

// >>> rtl/pin_sync.sv
// Three-stage input synchroniser with agreement filter, one per bit.
module pin_sync
  import seq_ctrl_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : gen_bit
      logic s1_q, s2_q, s3_q, lvl_q;
      logic lvl_d;

      // The level changes only once the second and third stages agree.
      always_comb begin
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
      end

      // Shift chain; the first stage feeds only the second.
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q  <= pin_i[g];
          s2_q  <= s1_q;
          s3_q  <= s2_q;
          lvl_q <= lvl_d;
        end
      end

      assign level_o[g] = lvl_q;
    end
  endgenerate

endmodule

// >>> rtl/seq_start_ctrl.sv
// Sequence control front end: activation, auto/manual start, homing and jump interpreter.
// Function
// - Enable plus control start activates position loop
// - Auto select high: launch starts chosen program
// - Auto select low selects manual jog mode
// - Auto dropped while moving stops axis, aborts
// - Aborted program restarts from beginning only
// - Manual mode launch rising edge starts homing
// - Terminal actuation only under two-input setting; code also starts on auto select rise under SET_TERM
// - Start-with-control setting launches program on control
// - Each command takes 1ms unless excepted
// - Jump goes to line, end, or subroutine
// - Conditional jump on in-window flag
// - Conditional jump on target-reached flag
// - Conditional jump on flag, direct or indexed
// - Variable compare less/equal/greater, direct or indexed
// - Outputs show controller ready and energised standstill
// - Launch edge starts only if auto already set
module seq_start_ctrl
  import seq_ctrl_pkg::*;
#(
  parameter int START_DELAY_CYCLES = START_DELAY_CYC,
  parameter int CMD_CYCLES         = CMD_CYC,
  parameter int CMD_LONG_CYCLES    = CMD_LONG_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic                power_stage_enable_i,
  input  wire logic                control_start_input_i,
  input  wire logic                digital_input_1_i,
  input  wire logic                digital_input_2_i,
  input  wire logic                reference_cam_input_i,
  input  wire logic [2:0]          start_setting_i,
  input  wire logic [3:0]          program_start_line_i,
  input  wire logic                axis_moving_i,
  input  wire logic                in_window_flag_i,
  input  wire logic                target_reached_flag_i,
  input  wire logic                homing_done_i,
  input  wire logic [ADDR_W-1:0]   reg_addr_i,
  input  wire logic [INSTR_W-1:0]  reg_wdata_i,
  input  wire logic                reg_we_i,
  input  wire logic                reg_re_i,
  output logic      [INSTR_W-1:0]  reg_rdata_o,
  output logic                     ready_output_o,
  output logic                     standstill_output_o,
  output logic                     loop_active_o,
  output logic                     auto_mode_o,
  output logic                     stop_axis_o,
  output logic                     home_start_o,
  output logic                     seq_running_o
);

  pins_s pins;

  // Terminal inputs come from outside the clock domain.
  pin_sync #(
    .W (5)
  ) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .pin_i   ({reference_cam_input_i, digital_input_2_i, digital_input_1_i,
               control_start_input_i, power_stage_enable_i}),
    .level_o (pins)
  );

  // Activation: enable delay counter and loop state.
  logic [15:0] en_cnt_q, en_cnt_d;
  logic        loop_q, loop_d;
  logic        en_ok;

  assign en_ok = (en_cnt_q == 16'(START_DELAY_CYCLES));

  // The enable must stand for the delay before control start can close the loop.
  always_comb begin
    en_cnt_d = en_cnt_q;
    if (!pins.enable) begin
      en_cnt_d = CNT16_RST;
    end else if (!en_ok) begin
      en_cnt_d = en_cnt_q + 16'h0001;
    end
    loop_d = en_ok && pins.start;
  end

  // Activation registers.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      en_cnt_q <= CNT16_RST;
      loop_q   <= 1'b0;
    end else begin
      en_cnt_q <= en_cnt_d;
      loop_q   <= loop_d;
    end
  end

  // Program, flag, counter and variable storage.
  instr_s            prog_q [PROG_DEPTH];
  instr_s            prog_d [PROG_DEPTH];
  logic [NUM_FLAGS-1:0] flags_q, flags_d;
  logic [7:0]        cnt_q  [NUM_CNT];
  logic [7:0]        cnt_d  [NUM_CNT];
  logic signed [15:0] var_q [NUM_VAR];
  logic signed [15:0] var_d [NUM_VAR];

  // Software writes program lines, flags, counters and variables.
  always_comb begin
    prog_d  = prog_q;
    flags_d = flags_q;
    cnt_d   = cnt_q;
    var_d   = var_q;
    if (reg_we_i) begin
      if (reg_addr_i[5:4] == ADDR_PROG_BASE[5:4]) begin
        prog_d[reg_addr_i[3:0]] = instr_s'(reg_wdata_i);
      end else if (reg_addr_i == ADDR_FLAGS) begin
        flags_d = reg_wdata_i[NUM_FLAGS-1:0];
      end else if (reg_addr_i[5:2] == ADDR_CNT_BASE[5:2]) begin
        cnt_d[reg_addr_i[1:0]] = reg_wdata_i[7:0];
      end else if (reg_addr_i[5:2] == ADDR_VAR_BASE[5:2]) begin
        var_d[reg_addr_i[1:0]] = reg_wdata_i[15:0];
      end
    end
  end

  // Storage registers.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < PROG_DEPTH; i++) begin
        prog_q[i] <= instr_s'(24'h000000);
      end
      for (int i = 0; i < NUM_CNT; i++) begin
        cnt_q[i] <= 8'h00;
        var_q[i] <= 16'sh0000;
      end
      flags_q <= 4'h0;
    end else begin
      prog_q  <= prog_d;
      flags_q <= flags_d;
      cnt_q   <= cnt_d;
      var_q   <= var_d;
    end
  end

  // Jump test on the current program line.
  logic [3:0] pc_q, pc_d, ret_q, ret_d;
  instr_s     cur;
  logic [1:0] cidx;
  logic       take;
  logic       long_cmd;

  // Signed relation test shared by all compare jumps.
  function automatic logic rel_ok(input rel_e r, input logic signed [15:0] a,
                                  input logic signed [15:0] b);
    logic res;
    res = 1'b0;
    case (r)
      REL_LESS:    res = (a < b);
      REL_EQUAL:   res = (a == b);
      REL_GREATER: res = (a > b);
      default:     res = 1'b0;
    endcase
    return res;
  endfunction

  // Current line and the flag or variable index taken from a counter.
  assign cur  = prog_q[pc_q];
  assign cidx = cnt_q[cur.idx_a][1:0];

  // Evaluates the condition of the current line.
  always_comb begin
    take     = 1'b0;
    long_cmd = 1'b0;
    unique case (cur.op)
      OP_JMP:       take = 1'b1;
      OP_JMP_WIN: begin
        take     = (in_window_flag_i == cur.bit_val);
        long_cmd = 1'b1;
      end
      OP_JMP_TGT:   take = (target_reached_flag_i == cur.bit_val);
      OP_JMP_FLAG:  take = (flags_q[cur.idx_a] == cur.bit_val);
      OP_JMP_FLAGX: take = (flags_q[cidx] == cur.bit_val);
      OP_JMP_VARK:  take = rel_ok(cur.rel, var_q[cur.idx_a], 16'(signed'(cur.konst)));
      OP_JMP_VARXK: take = rel_ok(cur.rel, var_q[cidx], 16'(signed'(cur.konst)));
      OP_JMP_VARV:  take = rel_ok(cur.rel, var_q[cur.idx_a], var_q[cur.idx_b]);
      OP_JMP_CNT:   take = rel_ok(cur.rel, {8'h00, cnt_q[cur.idx_a]}, {9'h000, cur.konst});
      OP_NOP, OP_END: take = 1'b0;
      default:      take = 1'b0;
    endcase
  end

  // Sequencer state, return line and line timer.
  seq_state_e  state_q, state_d;
  logic        ret_v_q, ret_v_d;
  logic [15:0] tick_q, tick_d;
  logic        auto_prev_q, launch_prev_q, loop_prev_q;
  logic        stop_q, stop_d, home_q, home_d;
  logic        std_set, launch_rise, start_req, home_req, last_tick;

  // Start and homing requests from the synchronised terminal levels.
  assign std_set     = (start_setting_i == SET_TWO_INPUT);
  assign launch_rise = pins.launch && !launch_prev_q;
  assign start_req   = loop_q && (
      (std_set && launch_rise && auto_prev_q && pins.auto_sel) ||
      ((start_setting_i == SET_CTRL) && !loop_prev_q) ||
      ((start_setting_i == SET_TERM) && pins.auto_sel && !auto_prev_q));
  assign home_req    = loop_q && std_set && !pins.auto_sel && launch_rise;
  assign last_tick   = (tick_q == (long_cmd ? 16'(CMD_LONG_CYCLES - 1)
                                            : 16'(CMD_CYCLES - 1)));

  // Start, abort, homing and line stepping.
  always_comb begin
    state_d = state_q;
    pc_d    = pc_q;
    ret_d   = ret_q;
    ret_v_d = ret_v_q;
    tick_d  = tick_q;
    stop_d  = 1'b0;
    home_d  = 1'b0;
    if (!loop_q) begin
      state_d = SEQ_IDLE;
    end else begin
      unique case (state_q)
        SEQ_IDLE: begin
          if (start_req) begin
            state_d = SEQ_RUN;
            pc_d    = program_start_line_i;
            ret_v_d = 1'b0;
            tick_d  = CNT16_RST;
          end else if (home_req) begin
            state_d = SEQ_HOME;
            home_d  = 1'b1;
          end
        end
        SEQ_RUN: begin
          if (std_set && !pins.auto_sel) begin
            state_d = SEQ_IDLE;
            stop_d  = axis_moving_i;
          end else if (!last_tick) begin
            tick_d = tick_q + 16'h0001;
          end else begin
            tick_d = CNT16_RST;
            pc_d   = pc_q + 4'h1;
            if (cur.op == OP_END || (take && cur.tgt == TGT_END)) begin
              if (ret_v_q) begin
                pc_d    = ret_q;
                ret_v_d = 1'b0;
              end else begin
                state_d = SEQ_IDLE;
              end
            end else if (take && cur.tgt == TGT_CALL) begin
              ret_d   = pc_q + 4'h1;
              ret_v_d = 1'b1;
              pc_d    = cur.line;
            end else if (take) begin
              pc_d = cur.line;
            end
          end
        end
        SEQ_HOME: begin
          if (homing_done_i) begin
            state_d = SEQ_IDLE;
          end
        end
        default: state_d = SEQ_IDLE;
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q       <= SEQ_IDLE;
      pc_q          <= LINE_RST;
      ret_q         <= LINE_RST;
      ret_v_q       <= 1'b0;
      tick_q        <= CNT16_RST;
      stop_q        <= 1'b0;
      home_q        <= 1'b0;
      auto_prev_q   <= 1'b0;
      launch_prev_q <= 1'b0;
      loop_prev_q   <= 1'b0;
    end else begin
      state_q       <= state_d;
      pc_q          <= pc_d;
      ret_q         <= ret_d;
      ret_v_q       <= ret_v_d;
      tick_q        <= tick_d;
      stop_q        <= stop_d;
      home_q        <= home_d;
      auto_prev_q   <= pins.auto_sel;
      launch_prev_q <= pins.launch;
      loop_prev_q   <= loop_q;
    end
  end

  // Output registers.
  logic [INSTR_W-1:0] rdata_q, rdata_d;
  logic ready_q, still_q, auto_q, run_q;

  // Read data answer in the cycle after the strobe and are zero otherwise.
  always_comb begin
    rdata_d = '0;
    if (reg_re_i) begin
      if (reg_addr_i[5:4] == ADDR_PROG_BASE[5:4]) begin
        rdata_d = prog_q[reg_addr_i[3:0]];
      end else if (reg_addr_i == ADDR_FLAGS) begin
        rdata_d = {20'h00000, flags_q};
      end else if (reg_addr_i[5:2] == ADDR_CNT_BASE[5:2]) begin
        rdata_d = {16'h0000, cnt_q[reg_addr_i[1:0]]};
      end else if (reg_addr_i[5:2] == ADDR_VAR_BASE[5:2]) begin
        rdata_d = {8'h00, var_q[reg_addr_i[1:0]]};
      end else if (reg_addr_i == ADDR_STATUS) begin
        rdata_d = {13'h0000, ret_v_q, pc_q, state_q, pins.cam, auto_q, loop_q, en_ok};
      end
    end
  end

  // Terminal outputs and read data.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
      ready_q <= 1'b0;
      still_q <= 1'b0;
      auto_q  <= 1'b0;
      run_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ready_q <= en_ok;
      still_q <= loop_q && !axis_moving_i;
      auto_q  <= std_set ? pins.auto_sel : (state_q == SEQ_RUN);
      run_q   <= (state_d == SEQ_RUN);
    end
  end

  // Every output comes straight from a register.
  assign reg_rdata_o         = rdata_q;
  assign ready_output_o      = ready_q;
  assign standstill_output_o = still_q;
  assign loop_active_o       = loop_q;
  assign auto_mode_o         = auto_q;
  assign stop_axis_o         = stop_q;
  assign home_start_o        = home_q;
  assign seq_running_o       = run_q;

endmodule

// >>> verification/seq_start_checker.sv
// Port-level assertions for the sequence start and jump logic.
module seq_start_checker
  import seq_ctrl_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               rstn_i,
  input wire logic [2:0]         start_setting_i,
  input wire logic               axis_moving_i,
  input wire logic               ready_output_o,
  input wire logic               standstill_output_o,
  input wire logic               loop_active_o,
  input wire logic               auto_mode_o,
  input wire logic               stop_axis_o,
  input wire logic               home_start_o,
  input wire logic               seq_running_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // The loop may only close once the enable has stood long enough.
  loop_ready_a: assert property ($rose(loop_active_o) |-> ready_output_o)
    else $error("loop active without ready");
  start_loop_a: assert property ($rose(seq_running_o) |-> loop_active_o)
    else $error("program started without loop");
  start_auto_a: assert property ($rose(seq_running_o) && start_setting_i == SET_TWO_INPUT
    |-> $past(auto_mode_o))
    else $error("program started without prior auto select");
  abort_run_a: assert property (seq_running_o && !auto_mode_o
    && start_setting_i == SET_TWO_INPUT |-> ##[0:2] !seq_running_o)
    else $error("run not aborted after auto drop");
  stop_pulse_a: assert property (stop_axis_o |-> $past(axis_moving_i) ##1 !stop_axis_o)
    else $error("bad stop pulse");
  home_pulse_a: assert property (home_start_o |-> !auto_mode_o && !seq_running_o
    ##1 !home_start_o)
    else $error("bad homing pulse");
  home_mode_a: assert property (home_start_o |-> start_setting_i == SET_TWO_INPUT)
    else $error("homing under other setting");
  ctrl_start_a: assert property ($rose(loop_active_o) && start_setting_i == SET_CTRL
    |-> ##[0:2] seq_running_o)
    else $error("no start with control");
  standstill_a: assert property (standstill_output_o |-> !$past(axis_moving_i))
    else $error("standstill while moving");
endmodule

bind seq_start_ctrl seq_start_checker chk (
  .clk_i              (clk_i),
  .rstn_i             (rstn_i),
  .start_setting_i    (start_setting_i),
  .axis_moving_i      (axis_moving_i),
  .ready_output_o     (ready_output_o),
  .standstill_output_o(standstill_output_o),
  .loop_active_o      (loop_active_o),
  .auto_mode_o        (auto_mode_o),
  .stop_axis_o        (stop_axis_o),
  .home_start_o       (home_start_o),
  .seq_running_o      (seq_running_o)
);

// >>> verification/ctrl_model.sv
// Behavioural machine controller driving the terminal inputs.
module ctrl_model #(
  parameter int HOLD = 20
) (
  input  wire logic clk_i,
  output logic      enable_o,
  output logic      start_o,
  output logic      auto_o,
  output logic      launch_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // All terminals start released.
  initial begin
    enable_o = 1'b0;
    start_o = 1'b0;
    auto_o = 1'b0;
    launch_o = 1'b0;
  end

  // Enable first, control start a given gap later.
  task automatic power_up(input int gap);
    @(posedge clk_i);
    enable_o <= 1'b1;
    repeat (gap) @(posedge clk_i);
    start_o <= 1'b1;
  endtask

  task automatic set_start(input logic v);
    @(posedge clk_i);
    start_o <= v;
  endtask

  task automatic set_auto(input logic v);
    @(posedge clk_i);
    auto_o <= v;
  endtask

  // Start pulse held for the scaled minimum time, then released.
  task automatic pulse_launch();
    @(posedge clk_i);
    launch_o <= 1'b1;
    repeat (HOLD) @(posedge clk_i);
    launch_o <= 1'b0;
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the sequence start and jump logic.
module tb_top
  import seq_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        moving = 1'b0;
  logic        win = 1'b0;
  logic        tgt = 1'b0;
  logic        hdone = 1'b0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic [2:0]  sset = SET_TWO_INPUT;
  logic [5:0]  addr = 6'h00;
  logic [23:0] wdata = 24'h000000;
  logic [23:0] rdata;
  logic [23:0] rdv;
  logic [3:0]  p;
  logic [3:0]  pstart = 4'h2;
  logic        cam = 1'b0;
  logic [5:0]  ra [5] = '{ADDR_FLAGS, ADDR_CNT_BASE, ADDR_VAR_BASE, ADDR_STATUS, 6'h3F};
  logic [3:0]  flg;
  wire         en, st, au, la, rdy, sst, loop, amode, stop, hst, run;
  int          cnt[4];
  int          vr[4];
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  instr_s      x;

  // Clock and hang guard.
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end

  ctrl_model ctrl (.clk_i(clk_i), .enable_o(en), .start_o(st), .auto_o(au), .launch_o(la));

  seq_start_ctrl #(.START_DELAY_CYCLES(8), .CMD_CYCLES(4), .CMD_LONG_CYCLES(8)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .power_stage_enable_i(en), .control_start_input_i(st),
    .digital_input_1_i(au), .digital_input_2_i(la), .reference_cam_input_i(cam),
    .start_setting_i(sset), .program_start_line_i(pstart), .axis_moving_i(moving),
    .in_window_flag_i(win), .target_reached_flag_i(tgt), .homing_done_i(hdone),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .ready_output_o(rdy), .standstill_output_o(sst),
    .loop_active_o(loop), .auto_mode_o(amode), .stop_axis_o(stop),
    .home_start_o(hst), .seq_running_o(run));

  // Comparison, bus cycles and bounded waits.
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? loop : s == 1 ? run : s == 2 ? stop : hst;
  endfunction

  task automatic wait_on(input string n, input int s, input logic v);
    repeat (40) begin
      @(posedge clk_i);
      #1;
      if (pick(s) === v) break;
    end
    chk(n, {23'h0, v}, {23'h0, pick(s)});
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Expected outcome of a jump test.
  function automatic logic rel(input int a, input int b, input rel_e r);
    return r == REL_LESS ? a < b : r == REL_EQUAL ? a == b : a > b;
  endfunction

  function automatic logic cond(input instr_s i);
    int c;
    int k;
    c = cnt[i.idx_a] % 4;
    k = $signed(i.konst);
    case (i.op)
      OP_JMP:       return 1'b1;
      OP_JMP_WIN:   return win == i.bit_val;
      OP_JMP_TGT:   return tgt == i.bit_val;
      OP_JMP_FLAG:  return flg[i.idx_a] == i.bit_val;
      OP_JMP_FLAGX: return flg[c] == i.bit_val;
      OP_JMP_VARK:  return rel(vr[i.idx_a], k, i.rel);
      OP_JMP_VARXK: return rel(vr[c], k, i.rel);
      OP_JMP_VARV:  return rel(vr[i.idx_a], vr[i.idx_b], i.rel);
      default:      return rel(cnt[i.idx_a], int'(i.konst), i.rel);
    endcase
  endfunction

  // Main sequence.
  initial begin
    void'($urandom(32'h276C));
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 chk("outputs", 24'h0, {17'h0, rdy, sst, loop, amode, stop, hst, run});
    wr(ADDR_STATUS, 24'hFFFFFF);
    wr(6'h3F, 24'hFFFFFF);
    foreach (ra[j]) begin
      rd(ra[j], rdv);
      chk("reset read", 24'h0, rdv);
    end
    ctrl.power_up(1);
    cam <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 chk("early loop", 24'h0, {23'h0, loop});
    wait_on("loop", 0, 1'b1);
    repeat (2) @(posedge clk_i);
    #1 chk("ready standstill", 24'h3, {22'h0, rdy, sst});
    rd(ADDR_STATUS, rdv);
    chk("status", 24'hB, {20'h0, rdv[3:0]});
    x = '0;
    x.line = 4'h9;
    wr(ADDR_PROG_BASE + 6'h9, x);
    $display("test activation done");
    for (int k = 0; k < 18; k++) begin
      p = 4'($urandom_range(7, 2));
      pstart <= p;
      x = '0;
      x.line = p + 4'h1;
      wr(ADDR_PROG_BASE + 6'(x.line), x);
      x = instr_s'(24'($urandom));
      x.op = op_e'(k % 9);
      x.rel = rel_e'($urandom_range(2));
      x.tgt = $urandom_range(1) ? TGT_CALL : TGT_LINE;
      x.line = 4'h9;
      x.konst = 7'($urandom_range(8)) - 7'h04;
      flg = 4'($urandom);
      win <= 1'($urandom);
      tgt <= 1'($urandom);
      wr(ADDR_FLAGS, {20'h0, flg});
      for (int j = 0; j < 4; j++) begin
        cnt[j] = $urandom_range(7);
        vr[j] = $urandom_range(8) - 4;
        wr(6'(ADDR_CNT_BASE + j), 24'(cnt[j]));
        wr(6'(ADDR_VAR_BASE + j), 24'(vr[j]));
      end
      wr(ADDR_PROG_BASE + 6'(p), x);
      ctrl.set_auto(1'b1);
      repeat (6) @(posedge clk_i);
      fork
        ctrl.pulse_launch();
      join_none
      wait_on("run", 1, 1'b1);
      rd(ADDR_STATUS, rdv);
      chk("first pc", {20'h0, p}, {20'h0, rdv[9:6]});
      repeat (24) @(posedge clk_i);
      rd(ADDR_STATUS, rdv);
      chk("jump pc", cond(x) ? 24'h9 : {20'h0, p + 4'h1}, {20'h0, rdv[9:6]});
      chk("return", {23'h0, cond(x) && x.tgt == TGT_CALL}, {23'h0, rdv[10]});
      moving <= 1'b1;
      ctrl.set_auto(1'b0);
      wait_on("stop", 2, 1'b1);
      wait_on("abort", 1, 1'b0);
      moving <= 1'b0;
      $display("test jump %0d done", k);
    end
    fork
      ctrl.pulse_launch();
    join_none
    wait_on("homing", 3, 1'b1);
    chk("manual", 24'h0, {22'h0, amode, run});
    @(posedge clk_i);
    hdone <= 1'b1;
    @(posedge clk_i);
    hdone <= 1'b0;
    $display("test homing done");
    x = '0;
    x.op = OP_END;
    wr(ADDR_PROG_BASE + 6'h9, x);
    x.op = OP_JMP;
    x.line = 4'h3;
    wr(ADDR_PROG_BASE + 6'h3, x);
    x.tgt = TGT_CALL;
    x.line = 4'h9;
    wr(ADDR_PROG_BASE + 6'h2, x);
    pstart <= 4'h2;
    sset <= SET_CTRL;
    ctrl.set_start(1'b0);
    wait_on("loop off", 0, 1'b0);
    ctrl.set_start(1'b1);
    wait_on("ctrl run", 1, 1'b1);
    repeat (16) @(posedge clk_i);
    rd(ADDR_STATUS, rdv);
    chk("return line", 24'h3, {19'h0, rdv[10:6]});
    ctrl.set_start(1'b0);
    wait_on("loop lost", 1, 1'b0);
    $display("test start with control done");
    x = '0;
    x.tgt = TGT_END;
    wr(ADDR_PROG_BASE + 6'h3, x);
    sset <= SET_TERM;
    ctrl.set_start(1'b1);
    wait_on("loop on", 0, 1'b1);
    ctrl.set_auto(1'b1);
    wait_on("term run", 1, 1'b1);
    wait_on("term end", 1, 1'b0);
    $display("test single input start done");
    summarize();
  end
endmodule
